// [src/ndtw_pkg.sv]
// constants shared by the delay timer channels and the watchdog
// assumes a single 200 MHz clock and pins synchronised inside the top
package ndtw_pkg;
  localparam int          NUM_CHAN      = 9;
  localparam int          SEL_W         = 4;
  localparam int          DELAY_W       = 15;
  localparam int          PCNT_W        = 8;
  localparam int          WDC_W         = 32;
  localparam logic [3:0]  SRC_MARKER    = 4'hF;
  localparam logic [8:0]  PRESCALE_MASK = 9'h124;
  localparam logic [2:0]  PRESCALE_LAST = 3'h7;
  localparam int          CLK_PERIOD_NS = 5;
  localparam int          REF_HZ        = 1000000;
  localparam int          STEP_NS       = 500;
  localparam int          PULSE_NS      = 1000;
  localparam int          PULSE_CYC     = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          WD_PERIOD_MS  = 150;
  localparam int          WD_CYC        = (WD_PERIOD_MS * 1000000) / CLK_PERIOD_NS;
  localparam int          WD_RST_NS     = 1000;
  localparam int          WD_RST_CYC    = (WD_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// [src/ndtw_channel.sv]
// one delay channel: counts time-base ticks after a trigger, then pulses
// assumes tick is a one-cycle pulse on clk and trig comes from same domain
module ndtw_channel #(
  parameter int   DELAY_W      = ndtw_pkg::DELAY_W,
  parameter logic HAS_PRESCALE = 1'b0
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               trig,
  input  wire logic               tick,
  input  wire logic [DELAY_W-1:0] delay,
  input  wire logic               prescale_en,
  output logic                    expire,
  output logic                    pulse_out
);
  import ndtw_pkg::*;

  logic [DELAY_W:0]  cnt;
  logic [DELAY_W:0]  next_cnt;
  logic              running;
  logic              next_running;
  logic [2:0]        pre;
  logic [2:0]        next_pre;
  logic              next_expire;
  logic              next_pulse;
  logic [PCNT_W-1:0] pcnt;
  logic [PCNT_W-1:0] next_pcnt;
  logic              pre_on;
  logic              step;

  always_comb begin
    pre_on       = HAS_PRESCALE & prescale_en;
    step         = tick & (~pre_on | (pre == PRESCALE_LAST));
    next_pre     = pre;
    next_cnt     = cnt;
    next_running = running;
    next_expire  = 1'b0;
    next_pulse   = pulse_out;
    next_pcnt    = pcnt;
    if (trig) begin
      next_pre = 3'h0;
    end else if (tick && pre_on) begin
      next_pre = pre + 3'h1;
    end
    if (trig) begin
      // zero programs the longest delay, 32768 half-microsecond steps
      next_cnt     = (delay == '0) ? {1'b1, {DELAY_W{1'b0}}} : {1'b0, delay};
      next_running = 1'b1;
    end else if (running && step) begin
      if (cnt == {{DELAY_W{1'b0}}, 1'b1}) begin
        next_running = 1'b0;
        next_expire  = 1'b1;
      end else begin
        next_cnt = cnt - {{DELAY_W{1'b0}}, 1'b1};
      end
    end
    if (next_expire) begin
      next_pulse = 1'b1;
      next_pcnt  = '0;
    end else if (pulse_out) begin
      next_pcnt = pcnt + {{(PCNT_W-1){1'b0}}, 1'b1};
      if (pcnt == PCNT_W'(PULSE_CYC - 1)) begin
        next_pulse = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt       <= '0;
      running   <= 1'b0;
      pre       <= 3'h0;
      expire    <= 1'b0;
      pulse_out <= 1'b0;
      pcnt      <= '0;
    end else begin
      cnt       <= next_cnt;
      running   <= next_running;
      pre       <= next_pre;
      expire    <= next_expire;
      pulse_out <= next_pulse;
      pcnt      <= next_pcnt;
    end
  end

  property p_expire_pulse;
    @(posedge clk) disable iff (rst) expire |-> pulse_out && pcnt == '0;
  endproperty
  a_expire_pulse: assert property (p_expire_pulse) else $error("pulse not started at expiry");

  property p_pulse_min;
    @(posedge clk) disable iff (rst) pulse_out && pcnt != PCNT_W'(PULSE_CYC - 1) |=> pulse_out;
  endproperty
  a_pulse_min: assert property (p_pulse_min) else $error("output pulse too short");

  property p_pulse_max;
    @(posedge clk) disable iff (rst) pulse_out |-> pcnt < PCNT_W'(PULSE_CYC);
  endproperty
  a_pulse_max: assert property (p_pulse_max) else $error("output pulse too long");

  property p_trig_load;
    @(posedge clk) disable iff (rst) trig |=> running && cnt != '0 && !expire;
  endproperty
  a_trig_load: assert property (p_trig_load) else $error("trigger did not start the count");

  property p_pre_hold;
    @(posedge clk) disable iff (rst) running && pre_on && tick && pre != PRESCALE_LAST && !trig
      |=> $stable(cnt) && running;
  endproperty
  a_pre_hold: assert property (p_pre_hold) else $error("prescaler let a tick through");
endmodule

// [src/ndtw_top.sv]
// nine delay channels on a 2 MHz time base, plus the station watchdog
// assumes ref_1mhz and cycle_start_marker are asynchronous pins,
// wd_arm and wd_touch are one-cycle strobes from bus decode on clk
//
// Summary of operation
// - nine independent channels, zero to eight, each drive their own pulse output.
// - by default a channel starts its delay at the cycle start marker.
// - a static select lets a channel start from another channel's delayed output.
// - every channel counts on one 2 MHz tick made by doubling the 1 MHz reference.
// - delays run in half-microsecond steps up to 16384 microseconds.
// - channels two, five and eight have an enableable divide-by-eight for 4 us steps.
// - on expiry the channel drives a 1 microsecond output pulse.
// - the watchdog is idle until the processor arms it during initialisation.
// - the watchdog is a retriggerable one-shot of about 150 ms, each touch restarting it.
// - an access to the watchdog location retriggers it, done by the 15 Hz task.
// - if the one-shot runs out untouched, a system reset is asserted.
module ndtw_top #(
  parameter int WD_CYCLES = ndtw_pkg::WD_CYC
) (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic                         ref_1mhz,
  input  wire logic                         cycle_start_marker,
  input  wire logic [ndtw_pkg::DELAY_W-1:0] delay_set [ndtw_pkg::NUM_CHAN],
  input  wire logic [ndtw_pkg::SEL_W-1:0]   trig_sel  [ndtw_pkg::NUM_CHAN],
  input  wire logic [ndtw_pkg::NUM_CHAN-1:0] prescale_en,
  input  wire logic                         wd_arm,
  input  wire logic                         wd_touch,
  output logic      [ndtw_pkg::NUM_CHAN-1:0] chan_pulse,
  output logic                              system_reset
);
  import ndtw_pkg::*;

  // ************************************************************
  // pin synchronisers and time base
  // ************************************************************
  logic                ref_s1;
  logic                ref_s2;
  logic                ref_s3;
  logic                mk_s1;
  logic                mk_s2;
  logic                mk_s3;
  logic                tick;
  logic                marker_rise;
  logic [NUM_CHAN-1:0] expire;
  logic [NUM_CHAN-1:0] chan_trig;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_s1 <= 1'b0;
      ref_s2 <= 1'b0;
      ref_s3 <= 1'b0;
      mk_s1  <= 1'b0;
      mk_s2  <= 1'b0;
      mk_s3  <= 1'b0;
    end else begin
      ref_s1 <= ref_1mhz;
      ref_s2 <= ref_s1;
      ref_s3 <= ref_s2;
      mk_s1  <= cycle_start_marker;
      mk_s2  <= mk_s1;
      mk_s3  <= mk_s2;
    end
  end

  // both edges of the reference give the doubled rate without a real pll;
  // the 2 MHz phase follows the reference duty cycle
  assign tick        = ref_s2 ^ ref_s3;
  assign marker_rise = mk_s2 & ~mk_s3;

  // ************************************************************
  // channel trigger routing
  // ************************************************************
  function automatic logic pick_trig(input logic [SEL_W-1:0]    sel,
                                     input logic [NUM_CHAN-1:0] exp_v,
                                     input logic                mk);
    logic r;
    r = mk;
    if (sel < SEL_W'(NUM_CHAN)) begin
      r = exp_v[sel];
    end
    return r;
  endfunction

  for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
    assign chan_trig[i] = pick_trig(trig_sel[i], expire, marker_rise);
    ndtw_channel #(
      .DELAY_W      (DELAY_W),
      .HAS_PRESCALE (PRESCALE_MASK[i])
    ) u_chan (
      .clk         (clk),
      .rst         (rst),
      .trig        (chan_trig[i]),
      .tick        (tick),
      .delay       (delay_set[i]),
      .prescale_en (prescale_en[i]),
      .expire      (expire[i]),
      .pulse_out   (chan_pulse[i])
    );

    property p_marker_trig;
      @(posedge clk) disable iff (rst) trig_sel[i] >= SEL_W'(NUM_CHAN)
        |-> chan_trig[i] == marker_rise;
    endproperty
    a_marker_trig: assert property (p_marker_trig) else $error("marker misrouted");

    property p_chain_trig;
      @(posedge clk) disable iff (rst) trig_sel[i] < SEL_W'(NUM_CHAN)
        |-> chan_trig[i] == expire[trig_sel[i]];
    endproperty
    a_chain_trig: assert property (p_chain_trig) else $error("chain misrouted");
  end

  // ************************************************************
  // watchdog one-shot
  // ************************************************************
  typedef enum logic [1:0] {
    WD_IDLE = 2'b00,
    WD_RUN  = 2'b01,
    WD_FIRE = 2'b10
  } ndtw_wd_type;

  ndtw_wd_type      wd_state;
  ndtw_wd_type      next_wd_state;
  logic [WDC_W-1:0] wd_cnt;
  logic [WDC_W-1:0] next_wd_cnt;
  logic             next_system_reset;

  always_comb begin
    next_wd_state     = wd_state;
    next_wd_cnt       = wd_cnt;
    next_system_reset = system_reset;
    case (wd_state)
      WD_IDLE: begin
        if (wd_arm) begin
          next_wd_state = WD_RUN;
          next_wd_cnt   = '0;
        end
      end
      WD_RUN: begin
        if (wd_touch) begin
          next_wd_cnt = '0;
        end else if (wd_cnt == WDC_W'(WD_CYCLES - 1)) begin
          next_wd_state     = WD_FIRE;
          next_wd_cnt       = '0;
          next_system_reset = 1'b1;
        end else begin
          next_wd_cnt = wd_cnt + {{(WDC_W-1){1'b0}}, 1'b1};
        end
      end
      WD_FIRE: begin
        // stretched so the reset reaches every board on the bus
        if (wd_cnt == WDC_W'(WD_RST_CYC - 1)) begin
          next_wd_state     = WD_IDLE;
          next_wd_cnt       = '0;
          next_system_reset = 1'b0;
        end else begin
          next_wd_cnt = wd_cnt + {{(WDC_W-1){1'b0}}, 1'b1};
        end
      end
      default: begin
        next_wd_state     = WD_IDLE;
        next_wd_cnt       = '0;
        next_system_reset = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wd_state     <= WD_IDLE;
      wd_cnt       <= '0;
      system_reset <= 1'b0;
    end else begin
      wd_state     <= next_wd_state;
      wd_cnt       <= next_wd_cnt;
      system_reset <= next_system_reset;
    end
  end

  property p_tick_single;
    @(posedge clk) disable iff (rst) tick |=> !tick;
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("time base tick too wide");

  property p_wd_idle;
    @(posedge clk) disable iff (rst) wd_state == WD_IDLE && !wd_arm |=> wd_state == WD_IDLE
      && !system_reset;
  endproperty
  a_wd_idle: assert property (p_wd_idle) else $error("watchdog ran while unarmed");

  property p_wd_touch;
    @(posedge clk) disable iff (rst) wd_state == WD_RUN && wd_touch |=> wd_cnt == '0
      && wd_state == WD_RUN;
  endproperty
  a_wd_touch: assert property (p_wd_touch) else $error("touch did not restart watchdog");

  property p_wd_fire;
    @(posedge clk) disable iff (rst) wd_state == WD_RUN && !wd_touch
      && wd_cnt == WDC_W'(WD_CYCLES - 1) |=> system_reset && wd_state == WD_FIRE;
  endproperty
  a_wd_fire: assert property (p_wd_fire) else $error("watchdog expiry gave no reset");

  property p_wd_early;
    @(posedge clk) disable iff (rst) wd_state == WD_RUN && wd_cnt < WDC_W'(WD_CYCLES - 1)
      |=> !system_reset;
  endproperty
  a_wd_early: assert property (p_wd_early) else $error("watchdog reset came early");

  property p_rst_len;
    @(posedge clk) disable iff (rst) $rose(system_reset) |-> system_reset[*8];
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("system reset too short");

  property p_arm_run;
    @(posedge clk) disable iff (rst) wd_state == WD_IDLE && wd_arm |=> wd_state == WD_RUN
      && wd_cnt == '0;
  endproperty
  a_arm_run: assert property (p_arm_run) else $error("arm did not start watchdog");

  property p_run_count;
    @(posedge clk) disable iff (rst) wd_state == WD_RUN && !wd_touch
      && wd_cnt != WDC_W'(WD_CYCLES - 1) |=> wd_state == WD_RUN
      && wd_cnt == $past(wd_cnt) + {{(WDC_W-1){1'b0}}, 1'b1};
  endproperty
  a_run_count: assert property (p_run_count) else $error("watchdog count stalled");

  property p_fire_hold;
    @(posedge clk) disable iff (rst) wd_state == WD_FIRE |-> system_reset;
  endproperty
  a_fire_hold: assert property (p_fire_hold) else $error("reset dropped early");

  property p_rst_end;
    @(posedge clk) disable iff (rst) wd_state == WD_FIRE && wd_cnt == WDC_W'(WD_RST_CYC - 1)
      |=> !system_reset && wd_state == WD_IDLE;
  endproperty
  a_rst_end: assert property (p_rst_end) else $error("reset did not end");
endmodule

// [verification/ndtw_proc_model.sv]
// station processor stand-in: arms the watchdog and touches it periodically
// assumes the bench pulses arm_req for one cycle and holds keep_alive as a level
module ndtw_proc_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       arm_req,
  input  wire logic       keep_alive,
  input  wire logic [7:0] touch_gap,
  output logic            wd_arm,
  output logic            wd_touch
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // arming and periodic touches
  // ****************************************
  logic [7:0] gap;
  // touch_gap sets how slowly the periodic task answers; 0 gives back-to-back touches
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wd_arm   <= 1'b0;
      wd_touch <= 1'b0;
      gap      <= 8'h00;
    end else begin
      wd_arm   <= #1 arm_req;
      gap      <= (keep_alive && gap < touch_gap) ? gap + 8'h01 : 8'h00;
      wd_touch <= #1 keep_alive && gap == touch_gap;
    end
  end
endmodule

// [verification/ndtw_top_tb.sv]
// self-checking bench for the nine delay channels and the watchdog
// assumes ndtw_pkg, the design and ndtw_proc_model are compiled first
module ndtw_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import ndtw_pkg::*;
  localparam int TICK = STEP_NS / CLK_PERIOD_NS;
  localparam int WD   = 50;
  typedef struct {int ch; int t;} ndtw_note_type;
  // ****************************************
  // stimulus, scoreboard and checks
  // ****************************************
  logic                clk = 1'b0, rst = 1'b1, ref_1mhz = 1'b0, cycle_start_marker = 1'b0;
  logic                arm_req = 1'b0, keep_alive = 1'b0, cur, wd_arm, wd_touch, system_reset;
  logic [DELAY_W-1:0]  delay_set [NUM_CHAN];
  logic [SEL_W-1:0]    trig_sel  [NUM_CHAN];
  logic [NUM_CHAN-1:0] prescale_en = '0, chan_pulse;
  logic [7:0]          touch_gap = 8'h14;
  logic [7:0]          gaps [3] = '{8'h14, 8'h30, 8'h00};
  logic [9:0]          was = '0;
  int                  cyc = 0, cr = 0, last_take = 0, arm_take = 0, err_total = 0, n_checks = 0;
  int                  rise [10];
  ndtw_note_type       q [$], nt;

  always #2.5 clk = ~clk;
  // reference edges land one step after a clock edge, like every other input
  initial begin
    #3.5;
    forever #500 ref_1mhz = ~ref_1mhz;
  end

  ndtw_top #(.WD_CYCLES(WD)) ndtw_top_inst (.clk(clk), .rst(rst), .ref_1mhz(ref_1mhz),
    .cycle_start_marker(cycle_start_marker), .delay_set(delay_set), .trig_sel(trig_sel),
    .prescale_en(prescale_en), .wd_arm(wd_arm), .wd_touch(wd_touch),
    .chan_pulse(chan_pulse), .system_reset(system_reset));
  ndtw_proc_model ndtw_proc_model_inst (.clk(clk), .rst(rst), .arm_req(arm_req),
    .keep_alive(keep_alive), .touch_gap(touch_gap), .wd_arm(wd_arm), .wd_touch(wd_touch));

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wd_touch) last_take <= cyc + 1;
    if (wd_arm) arm_take <= cyc + 1;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // rises are matched in order; channel rises get a small window for sync latency
  always @(negedge clk) begin
    if (!rst) begin
      for (int i = 0; i < 10; i++) begin
        cur = (i < NUM_CHAN) ? chan_pulse[i] : system_reset;
        if (cur === 1'b1 && was[i] !== 1'b1) begin
          rise[i] = cyc;
          if (q.size() == 0) chk(i, 32'hFF);
          else begin
            nt = q.pop_front();
            chk(i, nt.ch);
            if (i < NUM_CHAN) chk(cyc, (cyc >= nt.t && cyc <= nt.t + 8) ? cyc : nt.t);
            else chk(cyc, nt.t);
          end
        end
        if (cur !== 1'b1 && was[i] === 1'b1) chk(cyc - rise[i], 200);
        was[i] = cur;
      end
    end
  end

  task automatic fire();
    @(ref_1mhz);
    @(posedge clk);
    cr = cyc + 1;
    repeat (19) @(posedge clk);
    #1 cycle_start_marker = 1'b1;
    repeat (4) @(posedge clk);
    #1 cycle_start_marker = 1'b0;
  endtask

  task automatic expect_all();
    int e [NUM_CHAN];
    int n, best;
    for (int i = 0; i < NUM_CHAN; i++) e[i] = -1;
    repeat (NUM_CHAN) for (int i = 0; i < NUM_CHAN; i++) begin
      n = (delay_set[i] == '0) ? 32768 : int'(delay_set[i]);
      if (prescale_en[i] && PRESCALE_MASK[i]) n = n * 8;
      if (trig_sel[i] >= SEL_W'(NUM_CHAN)) e[i] = n;
      else if (e[trig_sel[i]] >= 0) e[i] = e[trig_sel[i]] + n;
    end
    repeat (NUM_CHAN) begin
      best = -1;
      for (int i = 0; i < NUM_CHAN; i++)
        if (e[i] >= 0 && (best < 0 || e[i] < e[best])) best = i;
      q.push_back(ndtw_note_type'{best, cr + TICK * e[best]});
      e[best] = -1;
    end
  endtask

  task automatic drain();
    for (int k = 0; k < 20000 && q.size() > 0; k++) @(posedge clk);
    repeat (250) @(posedge clk);
    chk(32'(q.size()), 0);
    #1;
  endtask

  initial begin
    int base;
    void'($urandom(24));
    for (int i = 0; i < NUM_CHAN; i++) begin
      delay_set[i] = DELAY_W'(i + 1);
      trig_sel[i]  = SEL_W'($urandom_range(15, 9));
    end
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    // every channel from the marker, retriggered one tick into the count
    base = $urandom_range(3, 2);
    for (int i = 0; i < NUM_CHAN; i++) delay_set[i] = DELAY_W'(base + i);
    fire();
    fire();
    expect_all();
    drain();
    // prescale asked on all bits, only three channels may honour it
    prescale_en = '1;
    for (int i = 0; i < NUM_CHAN; i++) delay_set[i] = DELAY_W'(i + 1);
    fire();
    expect_all();
    drain();
    prescale_en = '0;
    // chains: 8 feeds 0, 3 feeds 4 feeds 7
    trig_sel[0] = 4'h8;
    trig_sel[4] = 4'h3;
    trig_sel[7] = 4'h4;
    for (int i = 0; i < NUM_CHAN; i++) delay_set[i] = DELAY_W'($urandom_range(4, 1));
    fire();
    expect_all();
    drain();
    // watchdog: idle touches ignored, then kept alive at several rates, then lapses
    foreach (gaps[g]) begin
      touch_gap  = 8'h14;
      keep_alive = 1'b1;
      repeat (150) @(posedge clk);
      // quiet spell longer than the interval: a watchdog armed by touches would fire here
      #1 keep_alive = 1'b0;
      repeat (2 * WD) @(posedge clk);
      #1 arm_req = 1'b1;
      keep_alive = 1'b1;
      touch_gap  = gaps[g];
      @(posedge clk);
      #1 arm_req = 1'b0;
      repeat (300) @(posedge clk);
      #1 keep_alive = 1'b0;
      repeat (2) @(posedge clk);
      q.push_back(ndtw_note_type'{9, (last_take > arm_take ? last_take : arm_take) + WD});
      drain();
    end
    arm_req = 1'b1;
    @(posedge clk);
    #1 arm_req = 1'b0;
    repeat (2) @(posedge clk);
    q.push_back(ndtw_note_type'{9, arm_take + WD});
    drain();
    results();
  end

  initial begin
    #400000;
    err_total++;
    results();
  end
endmodule
